/* rtl/ecb_event_bank.sv */
`timescale 1ns/1ps
`include "ecb_params.svh"
module ecb_event_bank #(
    parameter logic IS_FD = 1'b0,
    // Arbitrary identification values
    parameter logic [7:0] CODE_STD = 8'h5a,
    parameter logic [7:0] CODE_FD = 8'h5b
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic wakePin,
    input wire logic overheatEvt,
    input wire logic serialFailEvt,
    input wire logic frameErrEvt,
    input wire logic silenceEvt,
    input wire logic txdClampEvt,
    input wire logic vccUvEvt,
    input wire logic busWakeEvt,
    input wire logic [1:0] bus_mode_select,
    input wire logic modeNormal,
    input wire logic xcvrActive,
    input wire logic canOffline,
    input wire logic uvSleepForce,
    output logic rxdEventN,
    output logic sleepAllowed,
    output logic normal_entered_flag
);
    logic [7:0] sysEn, xcvrEn, wakeEn;
    logic [7:0] sysFlg, xcvrFlg, wakeFlg;
    logic [7:0] next_sysEn, next_xcvrEn, next_wakeEn;
    logic [7:0] next_sysFlg, next_xcvrFlg, next_wakeFlg;
    logic [7:0] sysSet, xcvrSet, wakeSet, summary;
    logic [7:0] next_rdData;
    logic next_rdValid, next_rxdN, next_sleepOk, next_nef;
    ecb_pkg::ecb_norm_t normSt, next_normSt;
    logic anyPending, regularWakeOn;

    ecb_edge_if wakeEdge ();

    ecb_wake_edge u_wake (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .wakePin(wakePin),
        .edge_o(wakeEdge)
    );

    // Address match, used by write and read decode
    function automatic logic hit(input logic [6:0] a, input logic [6:0] o);
        return a == o;
    endfunction

    // Write-one clear mask for one register
    function automatic logic [7:0] w1c(input logic wr, input logic [6:0] a,
                                       input logic [6:0] o, input logic [7:0] d);
        return (wr && hit(a, o)) ? d : 8'h00;
    endfunction

    // event set vectors, gated by enables except frame error, which is always captured
    always_comb begin
        sysSet = 8'h00;
        xcvrSet = 8'h00;
        wakeSet = 8'h00;
        sysSet[`ECB_SYS_OTW] = overheatEvt && modeNormal && sysEn[`ECB_SYS_OTW];
        sysSet[`ECB_SYS_SERIAL_FAIL_FLAG] = serialFailEvt && sysEn[`ECB_SYS_SERIAL_FAIL_FLAG];
        xcvrSet[`ECB_XC_FDE] = frameErrEvt;
        xcvrSet[`ECB_XC_CBS] = silenceEvt && xcvrEn[`ECB_XC_CBS];
        // CAN fault only in Normal with active transceiver
        xcvrSet[`ECB_XC_CF] = modeNormal && xcvrActive && xcvrEn[`ECB_XC_CF]
            && (txdClampEvt || (vccUvEvt && bus_mode_select == `ECB_MODE_01));
        xcvrSet[`ECB_XC_CW] = busWakeEvt && xcvrEn[`ECB_XC_CW];
        wakeSet[`ECB_WK_RISE] = wakeEdge.rise && wakeEn[`ECB_WK_RISE];
        wakeSet[`ECB_WK_FALL] = wakeEdge.fall && wakeEn[`ECB_WK_FALL];
    end

    // summary follows flags in the same cycle
    always_comb begin
        summary = 8'h00;
        summary[`ECB_SUM_WAKE] = |wakeFlg;
        summary[`ECB_SUM_XCVR] = |xcvrFlg;
        // system group, reserved bits stay zero
        summary[`ECB_SUM_SYS] = |sysFlg;
    end

    assign anyPending = |summary;
    assign regularWakeOn = xcvrEn[`ECB_XC_CW] || wakeEn[`ECB_WK_RISE] || wakeEn[`ECB_WK_FALL];

    // Enable and flag next values
    always_comb begin
        next_sysEn = sysEn;
        next_xcvrEn = xcvrEn;
        next_wakeEn = wakeEn;
        if (regWrEn && hit(regAddr, `ECB_ADR_SYS_EN)) begin
            next_sysEn = regWrData & `ECB_SYS_EN_MASK;
        end
        if (regWrEn && hit(regAddr, `ECB_ADR_XCVR_EN)) begin
            next_xcvrEn = regWrData & `ECB_XCVR_EN_MASK;
        end
        if (regWrEn && hit(regAddr, `ECB_ADR_WAKE_EN)) begin
            next_wakeEn = regWrData & `ECB_WAKE_MASK;
        end
        // clear on written ones, a same-cycle set wins
        next_sysFlg = ((sysFlg & ~w1c(regWrEn, regAddr, `ECB_ADR_SYS_FLG, regWrData))
            | sysSet) & `ECB_SYS_MASK;
        next_xcvrFlg = ((xcvrFlg & ~w1c(regWrEn, regAddr, `ECB_ADR_XCVR_FLG, regWrData))
            | xcvrSet) & `ECB_XCVR_MASK;
        next_wakeFlg = ((wakeFlg & ~w1c(regWrEn, regAddr, `ECB_ADR_WAKE_FLG, regWrData))
            | wakeSet) & `ECB_WAKE_MASK;
        // forced Sleep drops all flags, battery-up included
        if (uvSleepForce) begin
            next_sysFlg = `ECB_FLG_RST;
            next_xcvrFlg = `ECB_FLG_RST;
            next_wakeFlg = `ECB_FLG_RST;
            next_xcvrEn[`ECB_XC_CW] = 1'b1;
            next_wakeEn = `ECB_WAKE_MASK;
        end
    end

    // Read mux and status outputs
    always_comb begin
        next_rdValid = regRdEn;
        next_rdData = regRdData;
        if (regRdEn) begin
            unique case (1'b1)
                hit(regAddr, `ECB_ADR_SYS_EN): next_rdData = sysEn;
                hit(regAddr, `ECB_ADR_XCVR_EN): next_rdData = xcvrEn;
                hit(regAddr, `ECB_ADR_WAKE_EN): next_rdData = wakeEn;
                hit(regAddr, `ECB_ADR_SUMMARY): next_rdData = summary;
                hit(regAddr, `ECB_ADR_SYS_FLG): next_rdData = sysFlg;
                hit(regAddr, `ECB_ADR_XCVR_FLG): next_rdData = xcvrFlg;
                hit(regAddr, `ECB_ADR_WAKE_FLG): next_rdData = wakeFlg;
                hit(regAddr, `ECB_ADR_CHIP_ID): next_rdData = IS_FD ? CODE_FD : CODE_STD;
                default: next_rdData = 8'h00;
            endcase
        end
        // receive output low while offline with pending events
        next_rxdN = !(canOffline && anyPending);
        // Sleep permitted only with a wake source and no flags
        next_sleepOk = regularWakeOn && !anyPending;
    end

    // normal-entered bit cleared on first Normal entry
    always_comb begin
        next_normSt = normSt;
        next_nef = normal_entered_flag;
        unique case (normSt)
            ecb_pkg::ST_AWAIT_NORMAL: begin
                if (modeNormal) begin
                    next_normSt = ecb_pkg::ST_NORMAL_SEEN;
                    next_nef = 1'b0;
                end
            end
            ecb_pkg::ST_NORMAL_SEEN: begin
                next_normSt = normSt;
            end
            default: begin
                next_normSt = ecb_pkg::ST_AWAIT_NORMAL;
            end
        endcase
    end

    // State registers, frozen while clkEn is low
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sysEn <= `ECB_EN_RST;
            xcvrEn <= `ECB_EN_RST;
            wakeEn <= `ECB_EN_RST;
            // battery-up set coming out of power-on
            sysFlg <= `ECB_SYS_RST;
            xcvrFlg <= `ECB_FLG_RST;
            wakeFlg <= `ECB_FLG_RST;
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
            rxdEventN <= 1'b1;
            sleepAllowed <= 1'b0;
            normal_entered_flag <= 1'b1;
            normSt <= ecb_pkg::ST_AWAIT_NORMAL;
        end else if (clkEn) begin
            sysEn <= next_sysEn;
            xcvrEn <= next_xcvrEn;
            wakeEn <= next_wakeEn;
            sysFlg <= next_sysFlg;
            xcvrFlg <= next_xcvrFlg;
            wakeFlg <= next_wakeFlg;
            regRdData <= next_rdData;
            regRdValid <= next_rdValid;
            rxdEventN <= next_rxdN;
            sleepAllowed <= next_sleepOk;
            normal_entered_flag <= next_nef;
            normSt <= next_normSt;
        end
    end

    // Checks
    chk_w1c_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && regWrEn && hit(regAddr, `ECB_ADR_WAKE_FLG) && regWrData[0]
        && !wakeSet[0] && !uvSleepForce |=> !wakeFlg[0]) else $error("flag not cleared");
    chk_w0_keep: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && regWrEn && hit(regAddr, `ECB_ADR_SYS_FLG) && regWrData == 8'h00
        && !uvSleepForce |=> sysFlg == $past(sysFlg | sysSet)) else $error("zero write changed flag");
    chk_sum_wake: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && regRdEn && hit(regAddr, `ECB_ADR_SUMMARY)
        |=> regRdData[3] == $past(|wakeFlg)) else $error("summary wake bit wrong");
    chk_sum_xcvr: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && regRdEn && hit(regAddr, `ECB_ADR_SUMMARY)
        |=> regRdData[2] == $past(|xcvrFlg)) else $error("summary xcvr bit wrong");
    chk_sum_rsvd: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && regRdEn && hit(regAddr, `ECB_ADR_SUMMARY)
        |=> regRdData[7:4] == 4'h0 && !regRdData[1] && regRdData[0] == $past(|sysFlg))
        else $error("summary system or reserved bits wrong");
    chk_otw_set: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && overheatEvt && modeNormal && sysEn[2] && !uvSleepForce |=> sysFlg[2])
        else $error("overtemperature not captured");
    chk_serial_fail_flag_off: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && !sysFlg[1] && !sysEn[1] |=> !sysFlg[1]) else $error("disabled serial fail set");
    chk_po_uv: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && uvSleepForce |=> sysFlg == 8'h00 && wakeEn == 8'h03)
        else $error("forced sleep did not clear");
    chk_cf_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && !xcvrFlg[1] && !(modeNormal && xcvrActive) |=> !xcvrFlg[1])
        else $error("CAN fault outside Normal active");
    chk_rxd_low: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && canOffline && anyPending |=> !rxdEventN) else $error("receive line not low");
    chk_id_read: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && regRdEn && hit(regAddr, `ECB_ADR_CHIP_ID)
        |=> regRdValid && regRdData == (IS_FD ? CODE_FD : CODE_STD)) else $error("bad id");
    chk_nef_first: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && normSt == ecb_pkg::ST_AWAIT_NORMAL && modeNormal |=> !normal_entered_flag)
        else $error("normal entry not recorded");
    chk_fde_always: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && frameErrEvt && !uvSleepForce |=> xcvrFlg[5]) else $error("frame error lost");
    chk_rise_cap: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && wakeEdge.rise && wakeEn[1] && !uvSleepForce |=> wakeFlg[1])
        else $error("wake rise not captured");
    chk_sleep_block: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && anyPending |=> !sleepAllowed) else $error("sleep allowed with flags");
endmodule

/* rtl/ecb_params.svh */
`ifndef ECB_PARAMS_SVH
`define ECB_PARAMS_SVH

// Register addresses
`define ECB_ADR_SYS_EN 7'h04
`define ECB_ADR_XCVR_EN 7'h23
`define ECB_ADR_WAKE_EN 7'h4c
`define ECB_ADR_SUMMARY 7'h60
`define ECB_ADR_SYS_FLG 7'h61
`define ECB_ADR_XCVR_FLG 7'h63
`define ECB_ADR_WAKE_FLG 7'h64
`define ECB_ADR_CHIP_ID 7'h7e
// Field positions
`define ECB_SUM_WAKE 3
`define ECB_SUM_XCVR 2
`define ECB_SUM_SYS 0
`define ECB_SYS_PO 4
`define ECB_SYS_OTW 2
`define ECB_SYS_SERIAL_FAIL_FLAG 1
`define ECB_XC_FDE 5
`define ECB_XC_CBS 4
`define ECB_XC_CF 1
`define ECB_XC_CW 0
`define ECB_WK_RISE 1
`define ECB_WK_FALL 0
// Implemented-bit masks and reset values
`define ECB_SYS_MASK 8'h16
`define ECB_XCVR_MASK 8'h33
`define ECB_WAKE_MASK 8'h03
`define ECB_SYS_EN_MASK 8'h06
`define ECB_XCVR_EN_MASK 8'h13
`define ECB_SYS_RST 8'h10
`define ECB_FLG_RST 8'h00
`define ECB_EN_RST 8'h00
`define ECB_MODE_01 2'h1
`endif

/* rtl/ecb_pkg.sv */
package ecb_pkg;
    // Tracks first Normal entry after power-on
    typedef enum logic [1:0] {
        ST_AWAIT_NORMAL = 2'h1,
        ST_NORMAL_SEEN = 2'h2
    } ecb_norm_t;
endpackage

/* rtl/ecb_edge_if.sv */
`timescale 1ns/1ps
interface ecb_edge_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport snk (input rise, input fall);
endinterface

/* rtl/ecb_wake_edge.sv */
`timescale 1ns/1ps
module ecb_wake_edge (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic wakePin,
    ecb_edge_if.src edge_o
);
    logic s1, s2, s3, lvl;
    logic next_s1, next_s2, next_s3, next_lvl, next_rise, next_fall;
    logic rise, fall;

    // Three-stage sync, change accepted when stages two and three agree
    always_comb begin
        next_s1 = wakePin;
        next_s2 = s1;
        next_s3 = s2;
        next_lvl = lvl;
        next_rise = 1'b0;
        next_fall = 1'b0;
        if (s2 == s3 && s3 != lvl) begin
            next_lvl = s3;
            next_rise = s3;
            next_fall = !s3;
        end
    end

    // Registers, frozen while clkEn is low
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            lvl <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else if (clkEn) begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            lvl <= next_lvl;
            rise <= next_rise;
            fall <= next_fall;
        end
    end

    // Pulses are one-cycle events
    assign edge_o.rise = rise && clkEn;
    assign edge_o.fall = fall && clkEn;

    chk_edge_excl: assert property (@(posedge core_clk) disable iff (!arst_n)
        !(edge_o.rise && edge_o.fall)) else $error("both wake edges at once");
endmodule

/* dv/ecb_host_model.sv */
`timescale 1ns/1ps
module ecb_host_model (
    input wire logic core_clk,
    output logic [6:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid
);
    // Idle port at time zero
    initial begin
        regAddr = 7'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
        regWrData = ~d; // Stale data scrambled
    endtask

    // Read strobe, answer taken while valid stands
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
        regRdEn = 1'b0;
    endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
`include "ecb_params.svh"
module tb;
    localparam logic [7:0] ID_STD = 8'h3c; // Arbitrary code
    localparam logic [7:0] ID_FD = 8'h3d; // Arbitrary code
    logic core_clk, arst_n, clkEn, wakePin, modeNormal, xcvrActive, canOffline, uvForce;
    logic [1:0] busMode;
    logic [6:0] evts, regAddr;
    logic [7:0] regWrData, regRdData;
    logic regWrEn, regRdEn, regRdValid, rxdEventN, sleepAllowed, normalEntered;
    int errors, n_tests, cycles;

    ecb_host_model host (.core_clk(core_clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));

    ecb_event_bank #(.IS_FD(1'b0), .CODE_STD(ID_STD), .CODE_FD(ID_FD)) dut (
        .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .wakePin(wakePin), .overheatEvt(evts[0]),
        .serialFailEvt(evts[1]), .frameErrEvt(evts[2]), .silenceEvt(evts[3]),
        .txdClampEvt(evts[4]), .vccUvEvt(evts[5]), .busWakeEvt(evts[6]),
        .bus_mode_select(busMode), .modeNormal(modeNormal), .xcvrActive(xcvrActive),
        .canOffline(canOffline), .uvSleepForce(uvForce), .rxdEventN(rxdEventN),
        .sleepAllowed(sleepAllowed), .normal_entered_flag(normalEntered));

    // Clock, 40 ns period
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] expv, input logic [7:0] got);
        n_tests++;
        if (got !== expv) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic expect_reg(input logic [6:0] a, input logic [7:0] expv, input string what);
        logic [7:0] d;
        host.rd(a, d);
        check(what, expv, d);
    endtask

    // One-cycle event pulse
    task automatic fire(input int idx);
        @(negedge core_clk);
        evts[idx] = 1'b1;
        @(negedge core_clk);
        evts[idx] = 1'b0;
    endtask

    task automatic apply_reset();
        @(negedge core_clk);
        arst_n = 1'b0;
        repeat (6) @(negedge core_clk);
        arst_n = 1'b1;
    endtask

    task automatic t_reset();
        expect_reg(`ECB_ADR_SUMMARY, 8'h01, "summary");
        expect_reg(`ECB_ADR_SYS_FLG, 8'h10, "battery up");
        expect_reg(`ECB_ADR_CHIP_ID, ID_STD, "chip code");
        host.wr(`ECB_ADR_CHIP_ID, 8'hff);
        expect_reg(`ECB_ADR_CHIP_ID, ID_STD, "chip code ro");
        host.wr(`ECB_ADR_SUMMARY, 8'hff);
        expect_reg(`ECB_ADR_SUMMARY, 8'h01, "summary ro");
        expect_reg(7'h05, 8'h00, "unmapped");
        check("entered", 8'h01, {7'h00, normalEntered});
    endtask

    task automatic t_w1c();
        host.wr(`ECB_ADR_SYS_FLG, 8'hef);
        expect_reg(`ECB_ADR_SYS_FLG, 8'h10, "zeros kept");
        host.wr(`ECB_ADR_SYS_FLG, 8'h00);
        expect_reg(`ECB_ADR_SYS_FLG, 8'h10, "zero write");
        host.wr(`ECB_ADR_SYS_FLG, 8'h10);
        expect_reg(`ECB_ADR_SYS_FLG, 8'h00, "one clears");
        expect_reg(`ECB_ADR_SUMMARY, 8'h00, "summary idle");
    endtask

    task automatic t_sys();
        @(negedge core_clk);
        modeNormal = 1'b1;
        fire(0);
        fire(1);
        expect_reg(`ECB_ADR_SYS_FLG, 8'h00, "sys gated");
        host.wr(`ECB_ADR_SYS_EN, 8'hff);
        expect_reg(`ECB_ADR_SYS_EN, 8'h06, "sys enable");
        fire(0);
        expect_reg(`ECB_ADR_SYS_FLG, 8'h04, "overheat");
        fire(1);
        expect_reg(`ECB_ADR_SYS_FLG, 8'h06, "serial fail");
        expect_reg(`ECB_ADR_SUMMARY, 8'h01, "summary sys");
        check("entered", 8'h00, {7'h00, normalEntered});
        host.wr(`ECB_ADR_SYS_FLG, 8'h06);
    endtask

    task automatic t_xcvr();
        fire(2);
        fire(3);
        fire(4);
        fire(6);
        expect_reg(`ECB_ADR_XCVR_FLG, 8'h20, "frame err only");
        host.wr(`ECB_ADR_XCVR_EN, 8'hff);
        expect_reg(`ECB_ADR_XCVR_EN, 8'h13, "xcvr enable");
        fire(3);
        expect_reg(`ECB_ADR_XCVR_FLG, 8'h30, "silence");
        fire(6);
        expect_reg(`ECB_ADR_XCVR_FLG, 8'h31, "bus wake");
        fire(4);
        expect_reg(`ECB_ADR_XCVR_FLG, 8'h33, "clamp fault");
        expect_reg(`ECB_ADR_SUMMARY, 8'h04, "summary xcvr");
        host.wr(`ECB_ADR_XCVR_FLG, 8'h02);
        // Clamp while the transceiver is not active is not a fault
        @(negedge core_clk);
        xcvrActive = 1'b0;
        fire(4);
        expect_reg(`ECB_ADR_XCVR_FLG, 8'h31, "fault inactive");
        xcvrActive = 1'b1;
        fire(5);
        expect_reg(`ECB_ADR_XCVR_FLG, 8'h31, "uv mode 00");
        @(negedge core_clk);
        busMode = `ECB_MODE_01;
        fire(5);
        expect_reg(`ECB_ADR_XCVR_FLG, 8'h33, "uv mode 01");
        host.wr(`ECB_ADR_XCVR_FLG, 8'hff);
    endtask

    task automatic t_wake();
        host.wr(`ECB_ADR_WAKE_EN, 8'h01);
        @(negedge core_clk);
        wakePin = 1'b1;
        repeat (8) @(negedge core_clk);
        expect_reg(`ECB_ADR_WAKE_FLG, 8'h00, "rise gated");
        wakePin = 1'b0;
        repeat (8) @(negedge core_clk);
        expect_reg(`ECB_ADR_WAKE_FLG, 8'h01, "fall edge");
        host.wr(`ECB_ADR_WAKE_EN, 8'h02);
        wakePin = 1'b1;
        repeat (8) @(negedge core_clk);
        expect_reg(`ECB_ADR_WAKE_FLG, 8'h03, "rise edge");
        expect_reg(`ECB_ADR_SUMMARY, 8'h08, "summary wake");
        // Pin back to idle so a later reset sees no false edge
        wakePin = 1'b0;
    endtask

    task automatic t_offline();
        @(negedge core_clk);
        canOffline = 1'b1;
        repeat (3) @(negedge core_clk);
        check("rxd pending", 8'h00, {7'h00, rxdEventN});
        check("sleep blocked", 8'h00, {7'h00, sleepAllowed});
        host.wr(`ECB_ADR_WAKE_FLG, 8'h03);
        repeat (3) @(negedge core_clk);
        check("rxd released", 8'h01, {7'h00, rxdEventN});
        check("sleep ok", 8'h01, {7'h00, sleepAllowed});
    endtask

    task automatic t_uv();
        expect_reg(`ECB_ADR_SYS_FLG, 8'h10, "battery up again");
        // Clock enable low freezes capture
        @(negedge core_clk);
        clkEn = 1'b0;
        fire(2);
        @(negedge core_clk);
        clkEn = 1'b1;
        expect_reg(`ECB_ADR_XCVR_FLG, 8'h00, "frozen");
        fire(2);
        expect_reg(`ECB_ADR_XCVR_FLG, 8'h20, "frame err");
        @(negedge core_clk);
        uvForce = 1'b1;
        @(negedge core_clk);
        uvForce = 1'b0;
        expect_reg(`ECB_ADR_SYS_FLG, 8'h00, "uv battery up");
        expect_reg(`ECB_ADR_XCVR_FLG, 8'h00, "uv xcvr");
        expect_reg(`ECB_ADR_XCVR_EN, 8'h01, "uv bus wake en");
        expect_reg(`ECB_ADR_WAKE_EN, 8'h03, "uv wake en");
    endtask

    // Main sequence
    initial begin
        arst_n = 1'b0;
        clkEn = 1'b1;
        wakePin = 1'b0;
        modeNormal = 1'b0;
        xcvrActive = 1'b1;
        canOffline = 1'b0;
        uvForce = 1'b0;
        busMode = 2'h0;
        evts = 7'h00;
        errors = 0;
        n_tests = 0;
        cycles = 0;
        apply_reset();
        t_reset();
        t_w1c();
        t_sys();
        t_xcvr();
        t_wake();
        t_offline();
        apply_reset();
        t_uv();
        wrap_up();
    end
endmodule
